// ==== verilog/tdr_top.sv ====
/*
 * diagnostic block: sdram scan test, prbs bit error tester with remote
 * loopback request, four test indicators, software reset of data path.
 * assumes an ahb-lite master, an sdram sequencer taking one command per
 * req/ack handshake, and a framer that strobes one bit per ethernet slot.
 */
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module tdr_top
    import tdr_pkg::*;
#(
    parameter int MEM_AW = 22,
    parameter int MEM_DW = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic mem_test_strap,
    input wire logic line_test_pin,
    input wire logic ts_assigned,
    input wire logic loop_active,
    input wire logic wan_loop_det,
    input wire logic eth_tx_paused,
    output logic [2:0] mem_op,
    output logic mem_req,
    output logic [MEM_AW-1:0] mem_addr,
    output logic [MEM_DW-1:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [MEM_DW-1:0] mem_rdata,
    output logic bert_sel,
    input wire logic bert_tx_req,
    output logic bert_tx_bit,
    input wire logic bert_rx_valid,
    input wire logic bert_rx_bit,
    output logic remote_loop_req,
    output logic data_path_rst,
    output logic state_ind_hi,
    output logic state_ind_lo,
    output logic result_ind_a,
    output logic result_ind_b
);
    // memory scan sequencer steps
    typedef enum logic [2:0] {
        M_IDLE, M_INIT, M_MODE, M_REFR, M_WR, M_RD, M_DONE
    } tdr_mst_t;
    // every cell is written, then read back
    // strap low returns to idle at any step

    // whole state of the block
    // all zero at reset but the pattern register,
    // which would stall if it were all zero
    typedef struct packed {
        // memory scan
        tdr_mst_t mst;
        logic [MEM_AW-1:0] maddr;
        logic [MEM_DW-1:0] wdat;
        logic [2:0] mop;
        logic mreq;
        logic mdone;
        logic mfail;
        // pattern tester
        logic [PRBS_LEN-1:0] tx_lfsr;
        logic [PRBS_LEN-1:0] rx_sh;
        logic [5:0] good_cnt;
        logic [3:0] bad_cnt;
        logic in_sync;
        logic [9:0] err_hold;
        // control, soft reset, events
        logic line_test;
        logic rst_en;
        logic rst_cmd;
        logic pat_test;
        logic [3:0] srst_cnt;
        logic [NEV-1:0] ist;
        logic [NEV-1:0] imsk;
        // bus side and indicators
        logic wr_pend;
        logic [AW-1:0] wr_addr;
        logic [31:0] rdata;
        logic [3:0] ind;
    } tdr_st_t;

    // registered image and its next value
    tdr_st_t s_q;
    tdr_st_t s_d;
    logic active; // tester running
    logic addr_ph; // ahb address phase taken

    // active is combinational: the framer swaps
    // in the pattern in the cycle it is allowed

    // the receiver uses the same taps, so a loop
    // returns the stream one slot bit later
    // next prbs state, x^15 + x^14 + 1
    function automatic logic [PRBS_LEN-1:0] prbs_next(input logic [PRBS_LEN-1:0] s);
        prbs_next = {s[PRBS_LEN-2:0], s[PRBS_LEN-1] ^ s[PRBS_LEN-2]};
    endfunction

    // address dependent data catches address
    // line faults during the read pass
    // test data stored at a memory address
    function automatic logic [MEM_DW-1:0] mem_pat(input logic [MEM_AW-1:0] a);
        logic [31:0] w;
        w = 32'(a);
        mem_pat = w[MEM_DW-1:0] ^ MEM_SEED;
    endfunction

    // reads see this cycle's write, so a read
    // right after a write shows the new value
    // register read mux over a state image
    function automatic logic [31:0] rd_mux(input tdr_st_t s, input logic [AW-1:0] a,
                                           input logic act);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            OFS_CTL: begin
                r[B_RST_EN] = s.rst_en;
                r[B_RST_CMD] = s.rst_cmd;
                r[B_LINE_TEST] = s.line_test;
            end
            OFS_PAT: r[B_PAT_TEST] = s.pat_test;
            // status: results, code, sync, scan, tester
            OFS_STAT: r = {24'h0, act, s.mfail, s.mdone, s.in_sync, s.ind};
            OFS_ISTAT: r = {27'h0, s.ist};
            OFS_IMASK: r = {27'h0, s.imsk};
            default: r = 32'h0000_0000; // unmapped reads zero
        endcase
        rd_mux = r;
    endfunction

    // tester runs from any source, never during memory test or without slots
    assign active = (line_test_pin | s_q.line_test | s_q.pat_test)
                    & ts_assigned & ~mem_test_strap;
    assign addr_ph = hsel & htrans[1] & hready;

    // next state of everything
    always_comb begin
        logic [NEV-1:0] ev;
        logic rx_err;
        logic [31:0] wv;

        s_d = s_q;
        ev = '0;
        rx_err = 1'b0;
        wv = hwdata;

        // memory scan sequencer
        // a command stands until acknowledged;
        // the next one is set up on that edge
        if (!mem_test_strap) begin
            s_d.mst = M_IDLE; // leaving test mode aborts the scan
            s_d.mreq = 1'b0;
        end else begin
            unique case (s_q.mst)
                M_IDLE: begin
                    s_d.mst = M_INIT;
                    s_d.mop = OP_INIT;
                    s_d.mreq = 1'b1;
                    s_d.mdone = 1'b0;
                    s_d.mfail = 1'b0;
                    s_d.maddr = '0;
                end
                M_INIT: if (mem_ack) begin
                    s_d.mst = M_MODE;
                    s_d.mop = OP_MODE;
                end
                M_MODE: if (mem_ack) begin
                    s_d.mst = M_REFR;
                    s_d.mop = OP_REFR;
                end
                M_REFR: if (mem_ack) begin
                    s_d.mst = M_WR;
                    s_d.mop = OP_WRITE;
                end
                M_WR: if (mem_ack) begin
                    s_d.maddr = s_q.maddr + 1'b1;
                    if (&s_q.maddr) begin
                        s_d.mst = M_RD; // every cell written, read back
                        s_d.mop = OP_READ;
                    end
                end
                M_RD: if (mem_ack) begin
                    // a failure sticks until the next scan starts
                    if (mem_rdata != mem_pat(s_q.maddr)) begin
                        s_d.mfail = 1'b1;
                    end
                    s_d.maddr = s_q.maddr + 1'b1;
                    if (&s_q.maddr) begin
                        s_d.mst = M_DONE;
                        s_d.mreq = 1'b0;
                        s_d.mdone = 1'b1;
                    end
                end
                // results stay while the strap is high
                M_DONE: s_d.mst = M_DONE; // hold results until strap drops
            endcase
        end
        // write data follows next cycle's address
        s_d.wdat = mem_pat(s_d.maddr);

        // prbs transmitter, advances once per ethernet slot bit
        // the framer takes the bit with its request;
        // no slot, no request, no movement
        if (active && bert_tx_req) begin
            s_d.tx_lfsr = prbs_next(s_q.tx_lfsr);
        end

        // prbs receiver, self synchronising on the received bits
        // each bit is predicted from the fifteen before
        // it: no seed needed, one line error gives
        // about three mismatches; errors count in sync
        if (!active) begin
            s_d.in_sync = 1'b0;
            s_d.good_cnt = '0;
            s_d.bad_cnt = '0;
            s_d.err_hold = '0;
        end else if (bert_rx_valid) begin
            rx_err = bert_rx_bit != (s_q.rx_sh[PRBS_LEN-1] ^ s_q.rx_sh[PRBS_LEN-2]);
            s_d.rx_sh = {s_q.rx_sh[PRBS_LEN-2:0], bert_rx_bit};
            if (s_q.err_hold != '0) begin
                s_d.err_hold = s_q.err_hold - 1'b1;
            end
            // a mismatch breaks the clean run
            if (rx_err) begin
                s_d.good_cnt = '0;
                if (s_q.in_sync) begin
                    s_d.err_hold = ERR_HOLD;
                    ev[EV_BIT_ERR] = 1'b1;
                    s_d.bad_cnt = s_q.bad_cnt + 1'b1;
                    if (s_q.bad_cnt + 1'b1 >= LOSS_ERRS) begin
                        s_d.in_sync = 1'b0;
                        s_d.bad_cnt = '0;
                        ev[EV_SYNC_LOSS] = 1'b1;
                    end
                end
            end else begin
                if (s_q.good_cnt != SYNC_RUN) begin
                    s_d.good_cnt = s_q.good_cnt + 1'b1;
                end
                if (s_q.good_cnt + 1'b1 == SYNC_RUN) begin
                    s_d.in_sync = 1'b1;
                end
                if (s_q.good_cnt + 1'b1 == ERR_CLR_RUN) begin
                    s_d.bad_cnt = '0; // isolated errors forgotten
                end
            end
        end

        // soft reset pulse runs down and the command bit clears itself
        // only the data path sees this pulse; framing,
        // line interfaces and registers run on
        if (s_q.srst_cnt != '0) begin
            s_d.srst_cnt = s_q.srst_cnt - 1'b1;
            if (s_q.srst_cnt == 4'h1) begin
                s_d.rst_cmd = 1'b0;
                ev[EV_SRST_DONE] = 1'b1;
            end
        end

        // memory result edges as events
        ev[EV_MEM_DONE] = s_d.mdone & ~s_q.mdone;
        ev[EV_MEM_FAIL] = s_d.mfail & ~s_q.mfail;

        // ahb write data phase
        // address latched in the address phase, data
        // lands at the end of the next cycle
        s_d.wr_pend = addr_ph & hwrite;
        if (addr_ph) begin
            s_d.wr_addr = haddr[AW-1:0];
        end
        if (s_q.wr_pend) begin
            unique case (s_q.wr_addr)
                OFS_CTL: begin
                    s_d.rst_en = wv[B_RST_EN];
                    s_d.line_test = wv[B_LINE_TEST];
                    // enable comes from the same word; a
                    // running pulse is never restarted
                    if (wv[B_RST_CMD] && wv[B_RST_EN] && s_q.srst_cnt == '0) begin
                        s_d.rst_cmd = 1'b1;
                        s_d.srst_cnt = 4'(SRST_CYC);
                    end
                end
                OFS_PAT: s_d.pat_test = wv[B_PAT_TEST];
                OFS_ISTAT: s_d.ist = s_q.ist & ~wv[NEV-1:0];
                OFS_IMASK: s_d.imsk = wv[NEV-1:0];
                default: s_d.ist = s_d.ist; // unmapped writes ignored
            endcase
        end
        // a clear in the same cycle as a new event
        // loses, so no event is missed
        s_d.ist = s_d.ist | ev; // a new event beats a clear

        // indicators: state code then per-state result meaning
        // memory test outranks the tester; result
        // bits change meaning with the state code
        if (mem_test_strap) begin
            s_d.ind = {ST_MEMTEST, s_d.mdone, s_d.mfail};
        end else if (active) begin
            s_d.ind = {ST_BERT, ~s_d.in_sync, s_d.err_hold != '0};
        end else begin
            s_d.ind[3:2] = loop_active ? ST_LOOP : ST_NORMAL;
            s_d.ind[1] = s_d.srst_cnt != '0;
            s_d.ind[0] = wan_loop_det & eth_tx_paused;
        end

        // read data for the next data phase, seen after any write now landing
        // outside a read data phase the bus sees zero
        s_d.rdata = addr_ph && !hwrite ? rd_mux(s_d, haddr[AW-1:0], active) : 32'h0000_0000;
    end

    // state register
    // one register image; the asynchronous reset
    // loads constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.mst <= M_IDLE;
            s_q.tx_lfsr <= 15'h7FFF; // nonzero seed so the sequence runs
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    // data outputs come from the register image;
    // handshakes and enables are decoded
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // always okay
    assign hrdata = s_q.rdata;
    // level interrupt while an unmasked event waits
    assign irq = |(s_q.ist & s_q.imsk);
    // memory commands toward the sequencer
    assign mem_op = s_q.mop;
    assign mem_req = s_q.mreq;
    assign mem_addr = s_q.maddr;
    assign mem_wdata = s_q.wdat;
    // tester outputs toward the framer, and the data path reset
    assign bert_sel = active;
    assign bert_tx_bit = s_q.tx_lfsr[PRBS_LEN-1];
    assign remote_loop_req = active & (line_test_pin | s_q.line_test);
    assign data_path_rst = s_q.srst_cnt != '0;
    // indicator pins: state code, then results
    assign state_ind_hi = s_q.ind[3];
    assign state_ind_lo = s_q.ind[2];
    assign result_ind_a = s_q.ind[1];
    assign result_ind_b = s_q.ind[0];
endmodule

// ==== verilog/tdr_pkg.sv ====
/*
 * constants shared by the diagnostic and soft reset block: register
 * offsets, field positions, memory test opcodes, receiver thresholds.
 * assumes byte addressing on a 32-bit ahb-lite bus.
 */
package tdr_pkg;
    localparam int CLK_NS = 40; // hclk period
    localparam int AW = 13; // decoded address bits
    // register byte addresses
    localparam logic [12:0] OFS_CTL = 13'h0018; // page 00, offset 18h
    localparam logic [12:0] OFS_PAT = 13'h1104; // page 11, offset 04h
    localparam logic [12:0] OFS_STAT = 13'h0200; // block state
    localparam logic [12:0] OFS_ISTAT = 13'h0204; // sticky events
    localparam logic [12:0] OFS_IMASK = 13'h0208; // event mask
    // control field positions
    localparam int B_RST_EN = 4;
    localparam int B_RST_CMD = 5;
    localparam int B_LINE_TEST = 6;
    localparam int B_PAT_TEST = 2;
    // event bit positions
    localparam int EV_MEM_DONE = 0;
    localparam int EV_MEM_FAIL = 1;
    localparam int EV_SYNC_LOSS = 2;
    localparam int EV_BIT_ERR = 3;
    localparam int EV_SRST_DONE = 4;
    localparam int NEV = 5;
    // work state codes on the two state indicators
    localparam logic [1:0] ST_NORMAL = 2'h0;
    localparam logic [1:0] ST_MEMTEST = 2'h1;
    localparam logic [1:0] ST_LOOP = 2'h2;
    localparam logic [1:0] ST_BERT = 2'h3;
    // memory command codes toward the sdram sequencer
    localparam logic [2:0] OP_INIT = 3'h1;
    localparam logic [2:0] OP_MODE = 3'h2;
    localparam logic [2:0] OP_REFR = 3'h3;
    localparam logic [2:0] OP_WRITE = 3'h4;
    localparam logic [2:0] OP_READ = 3'h5;
    localparam logic [15:0] MEM_SEED = 16'hA5C3; // data pattern mix
    // soft reset pulse length
    localparam int SRST_NS = 160;
    localparam int SRST_CYC = (SRST_NS + CLK_NS - 1) / CLK_NS;
    // pattern receiver thresholds, in received bits
    localparam logic [5:0] SYNC_RUN = 6'h20; // clean run to declare sync
    localparam logic [3:0] LOSS_ERRS = 4'h8; // errors to declare loss
    localparam logic [5:0] ERR_CLR_RUN = 6'h10; // clean run clears errors
    localparam logic [9:0] ERR_HOLD = 10'h3FF; // bit error flag stretch
    localparam int PRBS_LEN = 15;
endpackage

// ==== testbench/tdr_sva.sv ====
/* checker for the diagnostic block: state codes, memory test order,
   tester gating, soft reset pulse. bound into tdr_top at the foot. */
`timescale 1ns/100ps
module tdr_chk
    import tdr_pkg::*;
#(
    parameter int MEM_AW = 22
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] hwdata,
    input wire logic mem_test_strap,
    input wire logic line_test_pin,
    input wire logic ts_assigned,
    input wire logic wan_loop_det,
    input wire logic eth_tx_paused,
    input wire logic [2:0] mem_op,
    input wire logic mem_req,
    input wire logic [MEM_AW-1:0] mem_addr,
    input wire logic mem_ack,
    input wire logic bert_sel,
    input wire logic remote_loop_req,
    input wire logic data_path_rst,
    input wire logic state_ind_hi,
    input wire logic state_ind_lo,
    input wire logic result_ind_a,
    input wire logic result_ind_b
);
    // one clock domain: clock and reset given once
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_state_mem: assert property (mem_test_strap [*2]
        |-> {state_ind_hi, state_ind_lo} == ST_MEMTEST) else $error("memtest code wrong");
    a_first_init: assert property ($rose(mem_req) && mem_test_strap
        |-> mem_op == OP_INIT) else $error("scan does not start with init");
    a_write_next: assert property (mem_ack && mem_op == OP_REFR && mem_test_strap
        |=> mem_op == OP_WRITE && mem_addr == '0) else $error("no write after refresh");
    a_a_low_run: assert property ((mem_test_strap [*2]) ##0 mem_req
        |-> !result_ind_a) else $error("done shown while running");
    a_no_slots: assert property (!ts_assigned
        |-> !bert_sel && !remote_loop_req) else $error("tester without slots");
    a_loop_req: assert property (bert_sel && line_test_pin
        |-> remote_loop_req) else $error("no loopback request");
    a_bert_code: assert property (bert_sel [*2]
        |-> {state_ind_hi, state_ind_lo} == ST_BERT) else $error("tester code wrong");
    a_srst_len: assert property ($rose(data_path_rst)
        |-> data_path_rst [*4] ##1 !data_path_rst) else $error("reset pulse length");
    a_srst_en: assert property ($rose(data_path_rst)
        |-> $past(hwdata[B_RST_EN])) else $error("reset without enable");
    a_a_srst: assert property ($rose(data_path_rst) && !bert_sel && !mem_test_strap
        |-> ##[0:2] result_ind_a) else $error("no reset pulse shown");
    a_b_pause: assert property ((!mem_test_strap && !bert_sel && wan_loop_det
        && eth_tx_paused) [*2] |-> result_ind_b) else $error("pause not shown");
endmodule

bind tdr_top tdr_chk #(.MEM_AW(MEM_AW)) u_chk (
    .hclk, .hresetn, .hwdata, .mem_test_strap, .line_test_pin, .ts_assigned,
    .wan_loop_det, .eth_tx_paused, .mem_op, .mem_req, .mem_addr, .mem_ack, .bert_sel,
    .remote_loop_req, .data_path_rst, .state_ind_hi, .state_ind_lo, .result_ind_a,
    .result_ind_b
);

// ==== testbench/tdr_far.sv ====
/* far side model: sdram answering one command per handshake, and a
   remote converter that loops the test pattern back.
   assumes the bench commands slow answers, read faults and line cuts. */
`timescale 1ns/100ps
module tdr_far
    import tdr_pkg::*;
#(
    parameter int MEM_AW = 4
) (
    input wire logic hclk,
    input wire logic [2:0] mem_op,
    input wire logic mem_req,
    input wire logic [MEM_AW-1:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    input wire logic slow,
    input wire logic bad,
    input wire logic ts_assigned,
    output logic bert_tx_req,
    input wire logic bert_tx_bit,
    output logic bert_rx_valid,
    output logic bert_rx_bit,
    input wire logic remote_loop_req,
    input wire logic manual,
    input wire logic cut,
    input wire logic flip
);
    logic [15:0] mem [2**MEM_AW]; // memory cells
    logic [1:0] wait_n = 2'h0; // answer delay
    logic [1:0] div = 2'h0; // slot bit spacing
    logic loop;
    // peer loops on request, or by hand when no request is sent
    assign loop = (remote_loop_req || manual) && !cut;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 16'h0;
        bert_tx_req = 1'b0;
        bert_rx_valid = 1'b0;
        bert_rx_bit = 1'b0;
    end
    // sdram: data line shows junk outside a read answer
    always @(posedge hclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (wait_n != 2'h0) begin
                wait_n <= wait_n - 2'h1;
            end else begin
                mem_ack <= 1'b1;
                wait_n <= slow ? 2'h3 : 2'h0;
                if (mem_op == OP_WRITE) mem[mem_addr] <= mem_wdata;
                if (mem_op == OP_READ) mem_rdata <= mem[mem_addr] ^ {15'h0, bad && mem_addr == 3};
            end
        end
    end
    // slot strobes and the returned bit; a cut line sends all ones
    always @(posedge hclk) begin
        div <= div + 2'h1;
        bert_tx_req <= ts_assigned && div == 2'h3;
        bert_rx_valid <= bert_tx_req;
        if (bert_tx_req) bert_rx_bit <= loop ? bert_tx_bit ^ flip : 1'b1;
    end
endmodule

// ==== testbench/tb_top.sv ====
/* self-checking bench: registers over ahb-lite, soft reset, memory scan,
   bit error tester from all three sources, state codes.
   assumes tdr_far stands for the sdram and the remote converter. */
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
    import tdr_pkg::*;
    localparam int MAW = 4; // small memory keeps the scan short
    logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic mem_test_strap = 1'b0, line_test_pin = 1'b0, ts_assigned = 1'b0;
    logic loop_active = 1'b0, wan_loop_det = 1'b0, eth_tx_paused = 1'b0;
    logic slow = 1'b0, bad = 1'b0, manual = 1'b0, cut = 1'b0, flip = 1'b0;
    logic [2:0] mem_op;
    logic [MAW-1:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    logic mem_req, mem_ack, bert_sel, bert_tx_req, bert_tx_bit, bert_rx_valid, bert_rx_bit;
    logic remote_loop_req, data_path_rst, state_ind_hi, state_ind_lo, result_ind_a, result_ind_b;
    int errors = 0, num_checks = 0, rst_cyc = 0, a_seen = 0;
    logic [2:0] ops [$]; // acknowledged memory commands
    tdr_top #(.MEM_AW(MAW)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .mem_test_strap,
        .line_test_pin, .ts_assigned, .loop_active, .wan_loop_det, .eth_tx_paused,
        .mem_op, .mem_req, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .bert_sel,
        .bert_tx_req, .bert_tx_bit, .bert_rx_valid, .bert_rx_bit, .remote_loop_req,
        .data_path_rst, .state_ind_hi, .state_ind_lo, .result_ind_a, .result_ind_b
    );
    tdr_far #(.MEM_AW(MAW)) far (
        .hclk, .mem_op, .mem_req, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .slow,
        .bad, .ts_assigned, .bert_tx_req, .bert_tx_bit, .bert_rx_valid, .bert_rx_bit,
        .remote_loop_req, .manual, .cut, .flip
    );
    initial begin
        hclk = 1'b0;
        forever #(CLK_NS / 2) hclk = ~hclk;
    end
    // monitors: reset pulse width, pulse seen in normal state, command log
    always @(posedge hclk) begin
        if (data_path_rst) rst_cyc++;
        if (result_ind_a && !state_ind_hi && !state_ind_lo) a_seen++;
        if (mem_ack) ops.push_back(mem_op);
    end
    // expected work state code
    function automatic logic [1:0] code(input logic mt, input logic bt, input logic lp);
        return mt ? ST_MEMTEST : bt ? ST_BERT : lp ? ST_LOOP : ST_NORMAL;
    endfunction
    // one single word transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [12:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {19'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic chkrd(input logic [12:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask
    // bounded wait for a level, then settle to the falling edge
    task automatic waitsig(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) @(posedge hclk);
        @(negedge hclk);
    endtask
    task automatic conclude();
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(CLK_NS * 60000);
        errors++;
        conclude();
    end
    initial begin
        logic lp, wl, ep;
        lp = 1'($urandom(2175));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        chkrd(OFS_CTL, 32'h0);
        chkrd(13'h0100, 32'h0);
        wr(OFS_CTL, 32'h20);
        repeat (8) @(posedge hclk);
        `CHK(rst_cyc, 0)
        wr(OFS_CTL, 32'h30);
        repeat (8) @(posedge hclk);
        `CHK(rst_cyc, SRST_CYC)
        `CHK(a_seen > 0, 1'b1)
        chkrd(OFS_CTL, 32'h10);
        `CHK(irq, 1'b0)
        wr(OFS_IMASK, 32'h10);
        @(negedge hclk);
        `CHK(irq, 1'b1)
        wr(OFS_ISTAT, 32'h10);
        @(negedge hclk);
        `CHK(irq, 1'b0)
        // random normal and loop states with pause flags
        for (int i = 0; i < 24; i++) begin
            lp = 1'($urandom_range(1, 0));
            wl = 1'($urandom_range(1, 0));
            ep = 1'($urandom_range(1, 0));
            @(posedge hclk);
            loop_active <= lp;
            wan_loop_det <= wl;
            eth_tx_paused <= ep;
            repeat (2) @(posedge hclk);
            @(negedge hclk);
            `CHK({state_ind_hi, state_ind_lo}, code(1'b0, 1'b0, lp))
            `CHK(result_ind_b, wl & ep)
        end
        // memory scan: fast, slow, then a faulty cell
        for (int k = 0; k < 3; k++) begin
            @(posedge hclk);
            loop_active <= 1'b0;
            slow <= (k == 1);
            bad <= (k == 2);
            mem_test_strap <= 1'b1;
            ops.delete();
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            `CHK({state_ind_hi, state_ind_lo}, code(1'b1, 1'b0, 1'b0))
            `CHK(result_ind_a, 1'b0)
            waitsig(result_ind_a, 1'b1, 800);
            `CHK(result_ind_a, 1'b1)
            `CHK(result_ind_b, k == 2)
            `CHK(ops.size(), 3 + 2 * 2**MAW)
            `CHK({ops[0], ops[1], ops[2]}, {OP_INIT, OP_MODE, OP_REFR})
            `CHK({ops[3], ops[18], ops[19]}, {OP_WRITE, OP_WRITE, OP_READ})
            chkrd(OFS_STAT, 32'h26 | (k == 2 ? 32'h41 : 32'h0));
            @(posedge hclk);
            mem_test_strap <= 1'b0;
        end
        chkrd(OFS_ISTAT, 32'h3);
        // tester from pin, line bit, pattern bit (looped by hand)
        for (int s = 0; s < 3; s++) begin
            @(posedge hclk);
            ts_assigned <= 1'b1;
            manual <= (s == 2);
            cut <= 1'b0;
            line_test_pin <= (s == 0);
            wr(OFS_CTL, {25'h0, s == 1, 6'h0});
            wr(OFS_PAT, {29'h0, s == 2, 2'h0});
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            `CHK({state_ind_hi, state_ind_lo}, code(1'b0, 1'b1, 1'b0))
            `CHK(bert_sel, 1'b1)
            `CHK(remote_loop_req, s < 2)
            waitsig(result_ind_a, 1'b0, 3000);
            `CHK(result_ind_a, 1'b0)
            waitsig(result_ind_b, 1'b0, 6000);
            `CHK(result_ind_b, 1'b0)
            @(posedge hclk);
            flip <= 1'b1;
            repeat (4) @(posedge hclk);
            flip <= 1'b0;
            waitsig(result_ind_b, 1'b1, 400);
            `CHK(result_ind_b, 1'b1)
            `CHK(result_ind_a, 1'b0)
            @(posedge hclk);
            cut <= 1'b1;
            waitsig(result_ind_a, 1'b1, 400);
            `CHK(result_ind_a, 1'b1)
        end
        // no slot assigned: no test, no request
        @(posedge hclk);
        ts_assigned <= 1'b0;
        line_test_pin <= 1'b1;
        wr(OFS_PAT, 32'h0);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        `CHK({bert_sel, remote_loop_req}, 2'h0)
        `CHK({state_ind_hi, state_ind_lo}, code(1'b0, 1'b0, 1'b0))
        conclude();
    end
endmodule
